/* File: common/dsm_pkg.sv */
package dsm_pkg;

  // register port geometry
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_IN_STATUS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONFIG     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT      = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_POSITION   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SCALE      = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MONITOR    = 8'h24;

  // configuration fields
  localparam int          CFG_W       = 2;
  localparam int          CFG_SRC_BIT = 0;
  localparam int          CFG_MON_BIT = 1;
  localparam logic [1:0]  CFG_RESET   = 2'h0;

  // encoder counter and unit conversion
  localparam int                 COUNT_W     = 32;
  localparam int                 SCALE_W     = 16;
  localparam int                 SCALE_SHIFT = 8;
  localparam logic [SCALE_W-1:0] SCALE_UNITY = 16'h0100;

  // quadrature phase steps (phase index difference, modulo four)
  localparam logic [1:0] PHASE_HOLD = 2'h0;
  localparam logic [1:0] PHASE_FWD  = 2'h1;
  localparam logic [1:0] PHASE_SKIP = 2'h2;
  localparam logic [1:0] PHASE_REV  = 2'h3;

  // interrupt bits
  localparam int IRQ_W       = 4;
  localparam int IRQ_ALARM   = 0;
  localparam int IRQ_READY   = 1;
  localparam int IRQ_TIMING  = 2;
  localparam int IRQ_ENC_ERR = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

  typedef struct packed {
    logic a;
    logic b;
  } quad_s;

  // raw driver-connector inputs, 1 = active
  typedef struct packed {
    logic alarm;
    logic pos_complete;
    logic limiting_condition;
    logic motor_moving;
    logic op_ready;
    logic timing_diff_input;
    logic timing_single_input;
    logic external_z_input;
  } drv_in_s;

  // input status word, bit 6 down to bit 0
  typedef struct packed {
    logic alarm;
    logic pos_complete;
    logic limiting_condition;
    logic motor_moving;
    logic op_ready;
    logic timing_combined;
    logic timing_single_input;
  } in_status_s;

  // system outputs toward the driver, bit 8 down to bit 0
  typedef struct packed {
    logic current_off_output;
    logic current_on_output;
    logic resolution_select;
    logic shaft_free;
    logic brake_release_output;
    logic data_select_bit0;
    logic data_select_bit1;
    logic data_select_bit2;
    logic torque_limit_release;
  } drv_out_s;

  localparam int IN_W  = $bits(in_status_s);
  localparam int OUT_W = $bits(drv_out_s);
  localparam int MON_W = IN_W + OUT_W;

endpackage

/* File: hw/quad_counter.sv */
`timescale 1ns/100ps
module quad_counter (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // selected encoder phases
  input  wire dsm_pkg::quad_s              phase_in,
  input  wire logic                        resync,
  // count and error
  output logic [dsm_pkg::COUNT_W-1:0]      count,
  output logic                             phase_error
);
  import dsm_pkg::*;

  quad_s              prev;
  quad_s              next_prev;
  logic [COUNT_W-1:0] next_count;
  logic               next_phase_error;
  logic [1:0]         delta;

  // gray position 00,01,11,10 mapped to 0..3
  function automatic logic [1:0] phase_of(input quad_s q);
    unique case ({q.a, q.b})
      2'b00: phase_of = 2'h0;
      2'b01: phase_of = 2'h1;
      2'b11: phase_of = 2'h2;
      2'b10: phase_of = 2'h3;
    endcase
  endfunction

  assign delta = phase_of(phase_in) - phase_of(prev);

  always_comb begin
    next_prev        = phase_in;
    next_count       = count;
    next_phase_error = 1'b0;
    if (!resync) begin
      unique case (delta)
        PHASE_FWD:  next_count = count + COUNT_W'(1);
        PHASE_REV:  next_count = count - COUNT_W'(1);
        PHASE_SKIP: next_phase_error = 1'b1;
        PHASE_HOLD: next_count = count;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev        <= '0;
      count       <= '0;
      phase_error <= 1'b0;
    end else begin
      prev        <= next_prev;
      count       <= next_count;
      phase_error <= next_phase_error;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_step_up;
    !resync && delta == PHASE_FWD |=> count == $past(count) + COUNT_W'(1);
  endproperty
  a_step_up: assert property (p_step_up) else $error("count did not step up");

  property p_step_down;
    !resync && delta == PHASE_REV |=> count == $past(count) - COUNT_W'(1);
  endproperty
  a_step_down: assert property (p_step_down) else $error("count did not step down");

  property p_hold;
    phase_in == prev |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without a phase edge");

  property p_resync;
    resync |=> $stable(count) && !phase_error;
  endproperty
  a_resync: assert property (p_resync) else $error("count moved on source switch");

endmodule // quad_counter

/* File: hw/unit_scaler.sv */
`timescale 1ns/100ps
module unit_scaler (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // raw count and gain
  input  wire logic [dsm_pkg::COUNT_W-1:0] count,
  input  wire logic [dsm_pkg::SCALE_W-1:0] scale,
  // user-unit result
  output logic [dsm_pkg::COUNT_W-1:0]      position
);
  import dsm_pkg::*;

  logic signed [COUNT_W+SCALE_W:0] product;
  logic        [COUNT_W-1:0]       next_position;

  // gain is unsigned fixed point with SCALE_SHIFT fraction bits
  always_comb begin
    product       = $signed(count) * $signed({1'b0, scale});
    next_position = product[SCALE_SHIFT +: COUNT_W];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      position <= '0;
    end else begin
      position <= next_position;
    end
  end

  property p_unity;
    @(posedge clock) disable iff (rst)
    scale == SCALE_UNITY |=> position == $past(count);
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain did not pass count");

endmodule // unit_scaler

/* File: hw/driver_signal_monitor.sv */
`timescale 1ns/100ps
module driver_signal_monitor (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // register port
  input  wire dsm_pkg::bus_req_s            bus_req,
  output logic [dsm_pkg::DATA_W-1:0]        rdata,
  // driver connector
  input  wire dsm_pkg::drv_in_s             drv_in,
  input  wire dsm_pkg::drv_out_s            drv_out,
  input  wire dsm_pkg::quad_s               drv_enc,
  input  wire dsm_pkg::quad_s               ext_enc,
  // command source
  input  wire logic                         interactive_mode,
  // results
  output logic [dsm_pkg::COUNT_W-1:0]       feedback_position,
  output logic                              irq
);
  import dsm_pkg::*;

  in_status_s         in_q;
  in_status_s         next_in_q;
  drv_out_s           out_q;
  drv_out_s           next_out_q;
  logic [MON_W-1:0]   mon_q;
  logic [MON_W-1:0]   next_mon;
  logic [CFG_W-1:0]   cfg_q;
  logic [CFG_W-1:0]   next_cfg;
  logic               src_d;
  logic               next_src_d;
  logic [SCALE_W-1:0] scale_q;
  logic [SCALE_W-1:0] next_scale;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   next_irq_status;
  logic [IRQ_W-1:0]   irq_en;
  logic [IRQ_W-1:0]   next_irq_en;
  logic [IRQ_W-1:0]   irq_event;
  logic [DATA_W-1:0]  next_rdata;
  logic [COUNT_W-1:0] encoder_count;
  logic               enc_phase_error;
  logic               resync;
  logic               wr_cfg;
  logic               wr_clear;
  logic               wr_enable;
  quad_s              enc_sel;

  assign wr_cfg    = bus_req.wr && bus_req.addr == OFS_CONFIG;
  assign wr_clear  = bus_req.wr && bus_req.addr == OFS_IRQ_CLEAR;
  assign wr_enable = bus_req.wr && bus_req.addr == OFS_IRQ_ENABLE;

  // signal status capture
  always_comb begin
    next_in_q.alarm               = drv_in.alarm;
    next_in_q.pos_complete        = drv_in.pos_complete;
    next_in_q.limiting_condition  = drv_in.limiting_condition;
    next_in_q.motor_moving        = drv_in.motor_moving;
    next_in_q.op_ready            = drv_in.op_ready;
    next_in_q.timing_single_input = drv_in.timing_single_input;
    next_in_q.timing_combined     = cfg_q[CFG_SRC_BIT] ? drv_in.external_z_input
                                                       : drv_in.timing_diff_input;
    next_out_q = drv_out;
    // live monitor gated by interactive mode and the CFG_MON_BIT config bit
    next_mon = mon_q;
    if (interactive_mode && cfg_q[CFG_MON_BIT]) begin
      next_mon = {out_q, in_q};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_q  <= '0;
      out_q <= '0;
      mon_q <= '0;
    end else begin
      in_q  <= next_in_q;
      out_q <= next_out_q;
      mon_q <= next_mon;
    end
  end

  assign enc_sel = cfg_q[CFG_SRC_BIT] ? ext_enc : drv_enc;
  // first cycle on a new source only reloads the phase history
  assign resync  = cfg_q[CFG_SRC_BIT] != src_d;

  quad_counter u_counter (
    .clock       (clock),
    .rst         (rst),
    .phase_in    (enc_sel),
    .resync      (resync),
    .count       (encoder_count),
    .phase_error (enc_phase_error)
  );

  unit_scaler u_scaler (
    .clock    (clock),
    .rst      (rst),
    .count    (encoder_count),
    .scale    (scale_q),
    .position (feedback_position)
  );

  // configuration and interrupt registers
  always_comb begin
    next_cfg   = cfg_q;
    next_scale = scale_q;
    next_src_d = cfg_q[CFG_SRC_BIT];
    next_irq_en = irq_en;
    if (wr_cfg) begin
      next_cfg = bus_req.wdata[CFG_W-1:0];
    end
    if (bus_req.wr && bus_req.addr == OFS_SCALE) begin
      next_scale = bus_req.wdata[SCALE_W-1:0];
    end
    if (wr_enable) begin
      next_irq_en = bus_req.wdata[IRQ_W-1:0];
    end
    irq_event              = '0;
    irq_event[IRQ_ALARM]   = next_in_q.alarm && !in_q.alarm;
    irq_event[IRQ_READY]   = next_in_q.op_ready && !in_q.op_ready;
    irq_event[IRQ_TIMING]  = next_in_q.timing_combined && !in_q.timing_combined;
    irq_event[IRQ_ENC_ERR] = enc_phase_error;
    // set wins over a clear in the same cycle
    next_irq_status = irq_status | irq_event;
    if (wr_clear) begin
      next_irq_status = (irq_status & ~bus_req.wdata[IRQ_W-1:0]) | irq_event;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q      <= CFG_RESET;
      src_d      <= 1'b0;
      scale_q    <= SCALE_UNITY;
      irq_en     <= '0;
      irq_status <= '0;
    end else begin
      cfg_q      <= next_cfg;
      src_d      <= next_src_d;
      scale_q    <= next_scale;
      irq_en     <= next_irq_en;
      irq_status <= next_irq_status;
    end
  end

  assign irq = |(irq_status & irq_en);

  // read data, valid only in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_IN_STATUS:  next_rdata = DATA_W'(in_q);
        OFS_OUT_STATUS: next_rdata = DATA_W'(out_q);
        OFS_CONFIG:     next_rdata = DATA_W'(cfg_q);
        OFS_COUNT:      next_rdata = encoder_count;
        OFS_POSITION:   next_rdata = feedback_position;
        OFS_SCALE:      next_rdata = DATA_W'(scale_q);
        OFS_IRQ_STATUS: next_rdata = DATA_W'(irq_status);
        OFS_IRQ_ENABLE: next_rdata = DATA_W'(irq_en);
        OFS_MONITOR:    next_rdata = DATA_W'(mon_q);
        default:        next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_in_alarm;
    1'b1 |=> in_q.alarm == $past(drv_in.alarm);
  endproperty
  a_in_alarm: assert property (p_in_alarm) else $error("alarm status not tracking input");

  property p_in_ready;
    bus_req.rd && bus_req.addr == OFS_IN_STATUS |=> rdata[IN_W-1:0] == $past(in_q)
      && rdata[DATA_W-1:IN_W] == '0;
  endproperty
  a_in_ready: assert property (p_in_ready) else $error("input status read wrong");

  property p_timing_ext;
    cfg_q[CFG_SRC_BIT] |=> in_q.timing_combined == $past(drv_in.external_z_input);
  endproperty
  a_timing_ext: assert property (p_timing_ext) else $error("timing bit not external Z");

  property p_timing_diff;
    !cfg_q[CFG_SRC_BIT] |=> in_q.timing_combined == $past(drv_in.timing_diff_input);
  endproperty
  a_timing_diff: assert property (p_timing_diff) else $error("timing bit not differential");

  property p_out_status;
    bus_req.rd && bus_req.addr == OFS_OUT_STATUS |=> ##0 rdata[OUT_W-1:0] == $past(out_q)
      ##0 out_q == $past(drv_out);
  endproperty
  a_out_status: assert property (p_out_status) else $error("output status read wrong");

  property p_monitor_hold;
    !interactive_mode |=> $stable(mon_q);
  endproperty
  a_monitor_hold: assert property (p_monitor_hold) else $error("monitor moved outside interactive");

  property p_monitor_live;
    interactive_mode && cfg_q[CFG_MON_BIT] |=> mon_q == $past({out_q, in_q});
  endproperty
  a_monitor_live: assert property (p_monitor_live) else $error("monitor did not refresh");

  property p_read_count;
    bus_req.rd && bus_req.addr == OFS_COUNT |=> rdata == $past(encoder_count);
  endproperty
  a_read_count: assert property (p_read_count) else $error("count read wrong");

  property p_irq_alarm;
    drv_in.alarm && !in_q.alarm && irq_en[IRQ_ALARM] && !wr_enable |=> irq;
  endproperty
  a_irq_alarm: assert property (p_irq_alarm) else $error("alarm edge gave no interrupt");

  property p_set_wins;
    irq_event[IRQ_ALARM] && wr_clear |=> irq_status[IRQ_ALARM];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

endmodule // driver_signal_monitor

/* File: tb/encoder_partner.sv */
`timescale 1ns/100ps
module encoder_partner (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           rst,
  // step command: 0 hold, 1 forward, 2 reverse, 3 double jump
  input  wire logic [1:0]     cmd,
  // phases toward the monitor
  output dsm_pkg::quad_s      phase
);
  import dsm_pkg::*;
  logic [1:0] idx;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idx <= 2'h0;
    end else begin
      idx <= idx + ((cmd == 2'h1) ? 2'h1 : (cmd == 2'h2) ? 2'h3 : (cmd == 2'h3) ? 2'h2 : 2'h0);
    end
  end
  // gray coded phase pair, one line changes per single step
  assign phase = {idx[1], idx[1] ^ idx[0]};
endmodule // encoder_partner

/* File: tb/test_driver_signal_monitor.sv */
`timescale 1ns/100ps
module test_driver_signal_monitor;
  import dsm_pkg::*;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  bus_req_s          bus_req = '0;
  logic [DATA_W-1:0] rdata;
  drv_in_s           drv_in = '0;
  drv_out_s          drv_out = '0;
  quad_s             drv_enc;
  quad_s             ext_enc;
  logic [1:0]        drv_cmd = 2'h0;
  logic [1:0]        ext_cmd = 2'h0;
  logic              interactive_mode = 1'b0;
  logic [31:0]       feedback_position;
  logic              irq;
  int                num_errors = 0;
  int                num_checks = 0;
  logic [31:0]       m_count;
  logic [15:0]       m_scale;
  logic [15:0]       m_mon;
  logic              m_src;
  logic [7:0]        ofs [8];
  logic [31:0]       rst_val [8];

  always #5 clock = ~clock;

  driver_signal_monitor u_driver_signal_monitor (
    .clock(clock), .rst(rst), .bus_req(bus_req), .rdata(rdata), .drv_in(drv_in),
    .drv_out(drv_out), .drv_enc(drv_enc), .ext_enc(ext_enc),
    .interactive_mode(interactive_mode), .feedback_position(feedback_position), .irq(irq));
  encoder_partner u_drv_encoder (.clock(clock), .rst(rst), .cmd(drv_cmd), .phase(drv_enc));
  encoder_partner u_ext_encoder (.clock(clock), .rst(rst), .cmd(ext_cmd), .phase(ext_enc));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 check(rdata, e);
  endtask

  // one encoder step on the chosen encoder; the model counts only the selected one
  task automatic step(input logic [1:0] c, input logic ext);
    @(posedge clock);
    if (ext) ext_cmd <= c;
    else drv_cmd <= c;
    @(posedge clock);
    ext_cmd <= 2'h0;
    drv_cmd <= 2'h0;
    repeat (3) @(posedge clock);
    if (ext == m_src) m_count += (c == 2'h1) ? 32'h1 : (c == 2'h2) ? 32'hFFFFFFFF : 32'h0;
  endtask

  function automatic logic [31:0] in_exp();
    return {25'h0, drv_in.alarm, drv_in.pos_complete, drv_in.limiting_condition,
            drv_in.motor_moving, drv_in.op_ready,
            m_src ? drv_in.external_z_input : drv_in.timing_diff_input,
            drv_in.timing_single_input};
  endfunction

  function automatic logic [31:0] pos_exp();
    logic signed [63:0] p;
    p = $signed(m_count) * $signed({16'h0, m_scale});
    return p[39:8];
  endfunction

  task automatic new_inputs();
    @(posedge clock);
    drv_in <= 8'($urandom);
    drv_out <= OUT_W'($urandom);
    repeat (3) @(posedge clock);
  endtask

  task automatic enc_check();
    rchk(OFS_COUNT, m_count);
    rchk(OFS_POSITION, pos_exp());
    check(feedback_position, pos_exp());
  endtask

  task final_report();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    final_report();
  end

  initial begin
    void'($urandom(54821));
    m_count = 32'h0;
    m_scale = 16'h0100;
    m_src = 1'b0;
    ofs = '{OFS_IN_STATUS, OFS_CONFIG, OFS_COUNT, OFS_POSITION, OFS_SCALE, OFS_IRQ_STATUS,
            OFS_IRQ_CLEAR, 8'h30};
    rst_val = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    foreach (ofs[i]) rchk(ofs[i], rst_val[i]);
    $display("test reset values done");
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CONFIG, 32'(s));
      m_src = s[0];
      repeat (4) begin
        new_inputs();
        rchk(OFS_IN_STATUS, in_exp());
        rchk(OFS_OUT_STATUS, 32'(drv_out));
      end
      wr(OFS_IN_STATUS, 32'hFFFFFFFF);
      rchk(OFS_IN_STATUS, in_exp());
    end
    $display("test status bits done");
    wr(OFS_CONFIG, 32'h0);
    m_src = 1'b0;
    m_scale = 16'($urandom_range(32767, 1));
    wr(OFS_SCALE, 32'(m_scale));
    repeat (3) @(posedge clock);
    repeat (5) step(2'h2, 1'b0);
    enc_check();
    repeat (20) step(2'($urandom_range(2, 1)), 1'b0);
    enc_check();
    wr(OFS_CONFIG, 32'h1);
    m_src = 1'b1;
    repeat (3) @(posedge clock);
    repeat (3) step(2'h1, 1'b0);
    repeat (12) step(2'($urandom_range(2, 1)), 1'b1);
    // driver encoder steps are ignored once the external one is chosen
    enc_check();
    $display("test encoder count done");
    @(posedge clock);
    drv_in <= '0;
    repeat (3) @(posedge clock);
    wr(OFS_IRQ_CLEAR, 32'hF);
    rchk(OFS_IRQ_STATUS, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h1);
    drv_in.alarm <= 1'b1;
    drv_in.op_ready <= 1'b1;
    repeat (3) @(posedge clock);
    rchk(OFS_IRQ_STATUS, 32'h3);
    check(32'(irq), 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h1);
    rchk(OFS_IRQ_STATUS, 32'h2);
    check(32'(irq), 32'h0);
    step(2'h3, 1'b1);
    drv_in.external_z_input <= 1'b1;
    wr(OFS_IRQ_ENABLE, 32'h8);
    rchk(OFS_IRQ_STATUS, 32'hE);
    check(32'(irq), 32'h1);
    rchk(OFS_COUNT, m_count);
    wr(OFS_IRQ_CLEAR, 32'hF);
    #1 check(32'(irq), 32'h0);
    drv_in.alarm <= 1'b0;
    repeat (2) @(posedge clock);
    // alarm edge in the same cycle as a clear write: the set must win
    bus_req <= '{addr: OFS_IRQ_CLEAR, wdata: 32'hF, wr: 1'b1, rd: 1'b0};
    drv_in.alarm <= 1'b1;
    @(posedge clock);
    bus_req.wr <= 1'b0;
    rchk(OFS_IRQ_STATUS, 32'h1);
    $display("test interrupts done");
    wr(OFS_CONFIG, 32'h3);
    interactive_mode <= 1'b1;
    new_inputs();
    m_mon = {drv_out, IN_W'(in_exp())};
    rchk(OFS_MONITOR, 32'(m_mon));
    interactive_mode <= 1'b0;
    new_inputs();
    rchk(OFS_MONITOR, 32'(m_mon));
    wr(OFS_CONFIG, 32'h1);
    interactive_mode <= 1'b1;
    new_inputs();
    rchk(OFS_MONITOR, 32'(m_mon));
    rchk(OFS_OUT_STATUS, 32'(drv_out));
    $display("test live monitor done");
    final_report();
  end
endmodule // test_driver_signal_monitor
